// [common/asr_pkg.sv]
package asr_pkg;
  // array organisation
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 8;
  // timing figures in ns, faster grade
  localparam int T_CYCLE_FAST_NS = 120;
  localparam int T_OE_ACC_FAST_NS = 60;
  localparam int T_WPULSE_FAST_NS = 80;
  localparam int T_DSETUP_FAST_NS = 45;
  localparam int T_OUTOFF_FAST_NS = 35;
  // timing figures in ns, slower grade
  localparam int T_CYCLE_SLOW_NS = 150;
  localparam int T_OE_ACC_SLOW_NS = 75;
  localparam int T_OUTOFF_SLOW_NS = 40;
  localparam int T_PD_SETUP_NS = 0;
  // least times round up to whole cycles, slower grade covers both
  localparam int CYC_ACCESS = (T_CYCLE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_OE_ACC = (T_OE_ACC_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_TURN = (T_OUTOFF_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RECOVER = CYC_ACCESS;
  localparam int CNT_W = 6;
  // sequencer states
  typedef enum logic [2:0] {
    ASR_IDLE = 3'b000,
    ASR_RD_WAIT = 3'b001,
    ASR_WR_TURN = 3'b010,
    ASR_WR_PULSE = 3'b011,
    ASR_WR_END = 3'b100,
    ASR_SLEEP = 3'b101,
    ASR_WAKE = 3'b110
  } asr_state_t;
endpackage

// [hdl/asr_host.sv]
`timescale 1ns/1ns
// Overview of operation
// [RULE_01] memory is 32768 bytes, 15-bit address, shared 8-bit data pins
// [RULE_02] write happens only while chip enable and store gate both low
// [RULE_03] store gate falling first keeps the memory's pins undriven
// [RULE_04] host never drives data while memory drives; release before writing
// [RULE_05] wait 120/150 ns after chip enable before sampling; space reads likewise
// [RULE_06] allow 60/75 ns after output gate low before read data valid
// [RULE_07] memory turns outputs off within 35/40 ns of store gate low
// [RULE_08] after power-down hold chip enable high one read cycle before access
// [RULE_09] data captured on first rising edge of store gate or chip enable
// [RULE_10] address stable from before write start until write ends
// [RULE_11] selected, gate high, output gate low reads addressed byte
// [RULE_12] chip enable high ignores accesses, pins undriven, contents kept
// [RULE_13] selected with both gates high leaves data pins undriven
module asr_host (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // user request port
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [asr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [asr_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_sleep,
  output logic o_ready,
  output logic o_rvalid,
  output logic [asr_pkg::DATA_W-1:0] o_rdata,
  // memory pins
  // [RULE_01] 15-bit address, byte data
  output logic [asr_pkg::ADDR_W-1:0] o_mem_addr,
  output logic o_chip_enable_n,
  output logic o_store_gate_n,
  output logic o_output_gate_n,
  input wire logic [asr_pkg::DATA_W-1:0] i_dq,
  output logic [asr_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe_n
);

  asr_pkg::asr_state_t state;
  logic [asr_pkg::CNT_W-1:0] cnt;
  // helper counters feed the checks only, never the sequencer
  logic [asr_pkg::CNT_W-1:0] sel_age;
  logic [asr_pkg::CNT_W-1:0] wake_age;

  // ==========================================================
  // sequencer
  // ==========================================================
  // every timed phase uses the slower grade so either part works
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= asr_pkg::ASR_IDLE;
      cnt <= '0;
      o_ready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_mem_addr <= '0;
      o_chip_enable_n <= 1'b1;
      o_store_gate_n <= 1'b1;
      o_output_gate_n <= 1'b1;
      o_dq <= '0;
      o_dq_oe_n <= 1'b1;
    end else begin
      o_rvalid <= 1'b0;
      case (state)
        asr_pkg::ASR_IDLE: begin
          // [RULE_12] deselected standby
          o_chip_enable_n <= 1'b1;
          o_output_gate_n <= 1'b1;
          o_dq_oe_n <= 1'b1;
          o_ready <= !i_sleep;
          if (i_sleep) begin
            state <= asr_pkg::ASR_SLEEP;
          end else if (i_req && o_ready) begin
            o_ready <= 1'b0;
            // [RULE_10] address set ahead
            o_mem_addr <= i_addr;
            o_dq <= i_wdata;
            o_chip_enable_n <= 1'b0;
            cnt <= '0;
            if (i_we) begin
              state <= asr_pkg::ASR_WR_TURN;
            end else begin
              // [RULE_06] gate low whole access
              // [RULE_11] read with output gate
              o_output_gate_n <= 1'b0;
              state <= asr_pkg::ASR_RD_WAIT;
            end
          end
        end
        asr_pkg::ASR_RD_WAIT: begin
          cnt <= cnt + 1'b1;
          // [RULE_05] access and spacing wait
          if (cnt == asr_pkg::CNT_W'(asr_pkg::CYC_ACCESS - 1)) begin
            o_rdata <= i_dq;
            o_rvalid <= 1'b1;
            o_output_gate_n <= 1'b1;
            o_chip_enable_n <= 1'b1;
            state <= asr_pkg::ASR_IDLE;
          end
        end
        asr_pkg::ASR_WR_TURN: begin
          // [RULE_03] gate low before any drive; [RULE_13] output gate stays high
          o_store_gate_n <= 1'b0;
          cnt <= cnt + 1'b1;
          // [RULE_04] [RULE_07] turnaround wait covers output-off time
          // counted from the store gate fall one cycle after entry, not from entry
          if (cnt == asr_pkg::CNT_W'(asr_pkg::CYC_TURN)) begin
            o_dq_oe_n <= 1'b0;
            cnt <= '0;
            state <= asr_pkg::ASR_WR_PULSE;
          end
        end
        asr_pkg::ASR_WR_PULSE: begin
          cnt <= cnt + 1'b1;
          // [RULE_02] overlap held a full cycle time
          if (cnt == asr_pkg::CNT_W'(asr_pkg::CYC_ACCESS - 1)) begin
            // [RULE_09] store gate rises first, captures data
            o_store_gate_n <= 1'b1;
            state <= asr_pkg::ASR_WR_END;
          end
        end
        asr_pkg::ASR_WR_END: begin
          // data and address held one cycle past the rising edge
          o_chip_enable_n <= 1'b1;
          o_dq_oe_n <= 1'b1;
          state <= asr_pkg::ASR_IDLE;
        end
        asr_pkg::ASR_SLEEP: begin
          o_ready <= 1'b0;
          cnt <= '0;
          if (!i_sleep) begin
            state <= asr_pkg::ASR_WAKE;
          end
        end
        asr_pkg::ASR_WAKE: begin
          cnt <= cnt + 1'b1;
          // [RULE_08] chip enable high one cycle time
          if (cnt == asr_pkg::CNT_W'(asr_pkg::CYC_RECOVER - 1)) begin
            state <= asr_pkg::ASR_IDLE;
          end
        end
        default: begin
          state <= asr_pkg::ASR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // check helpers
  // ==========================================================
  // cycles the chip has stayed selected, saturating at all ones
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_age <= '0;
    end else if (o_chip_enable_n) begin
      sel_age <= '0;
    end else if (sel_age != '1) begin
      sel_age <= sel_age + 1'b1;
    end
  end

  // cycles since power-down ended; saturated out of reset, no recovery owed
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wake_age <= '1;
    end else if (state == asr_pkg::ASR_SLEEP) begin
      wake_age <= '0;
    end else if (wake_age != '1) begin
      wake_age <= wake_age + 1'b1;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  // [RULE_04] no bus contention
  AST_NO_DRIVE_DURING_READ: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_04]
    !o_output_gate_n |-> o_dq_oe_n)
    else $error("host drives data while memory outputs enabled");
  // [RULE_03] store gate first
  AST_GATE_BEFORE_DRIVE: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_03]
    $fell(o_dq_oe_n) |-> !$past(o_store_gate_n, asr_pkg::CYC_TURN))
    else $error("data driven before turnaround");
  // [RULE_05] sample after access
  AST_READ_WAIT: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_05]
    $fell(o_chip_enable_n) && !o_output_gate_n |-> ##19 o_rvalid)
    else $error("read sampled at wrong time");
  // [RULE_05] never sample early
  AST_SAMPLE_AGE: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_05]
    o_rvalid |-> sel_age == asr_pkg::CNT_W'(asr_pkg::CYC_ACCESS))
    else $error("read data taken before access time");
  // [RULE_06] output gate settled
  AST_OE_ACCESS: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_06]
    o_rvalid |-> !$past(o_output_gate_n, asr_pkg::CYC_OE_ACC))
    else $error("output gate not low long enough");
  // [RULE_02] overlap inside selection
  AST_WRITE_OVERLAP: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_02]
    !o_store_gate_n |-> !o_chip_enable_n)
    else $error("store gate low outside selection");
  // [RULE_10] address held steady
  AST_ADDR_STABLE: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_10]
    !o_chip_enable_n && !$past(o_chip_enable_n) |-> $stable(o_mem_addr))
    else $error("address moved during access");
  // [RULE_09] gate ends write
  AST_GATE_RISES_FIRST: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_09]
    $rose(o_store_gate_n) |-> !o_chip_enable_n && !o_dq_oe_n ##1 o_chip_enable_n)
    else $error("write end order wrong");
  // [RULE_08] stay deselected on wake
  AST_WAKE_DESELECT: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_08]
    $fell(i_sleep) && state == asr_pkg::ASR_SLEEP |-> o_chip_enable_n [*8] ##1 o_chip_enable_n)
    else $error("access too soon after power-down");
  // [RULE_08] full recovery time
  AST_WAKE_RECOVERY: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_08]
    $fell(o_chip_enable_n) |-> wake_age >= asr_pkg::CNT_W'(asr_pkg::CYC_RECOVER))
    else $error("selection before power-down recovery ended");
  // [RULE_13] no read gate in write
  AST_NO_READ_GATE_IN_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_13]
    !o_store_gate_n |-> o_output_gate_n)
    else $error("output gate low during write");
  // [RULE_12] idle leaves bus alone
  AST_IDLE_QUIET: assert property (@(posedge i_clock) disable iff (!i_arst_n) // [RULE_12]
    state == asr_pkg::ASR_IDLE |-> o_chip_enable_n && o_store_gate_n && o_dq_oe_n)
    else $error("memory selected or driven while idle");
endmodule

// [verif/asr_mem_model.sv]
`timescale 1ns/1ns
// ====================
// byte-wide static memory seen at its pins
module asr_mem_model (
  // memory pins
  input wire logic [asr_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_chip_enable_n,
  input wire logic i_store_gate_n,
  input wire logic i_output_gate_n,
  input wire logic [asr_pkg::DATA_W-1:0] i_dq,
  output logic [asr_pkg::DATA_W-1:0] o_dq,
  output logic o_drive
);
  logic [asr_pkg::DATA_W-1:0] cells [0:32767];
  assign o_drive = !i_chip_enable_n && i_store_gate_n && !i_output_gate_n;
  assign o_dq = cells[i_addr];
  // first rising edge of the overlap
  always @(posedge i_chip_enable_n or posedge i_store_gate_n) begin
    if (i_chip_enable_n ^ i_store_gate_n) begin
      cells[i_addr] <= i_dq;
    end
  end
endmodule

// [verif/test_async_sram_32kx8_access.sv]
`timescale 1ns/1ns
// ====================
// self-checking bench for the memory host
module test_async_sram_32kx8_access;
  logic i_clock = 1'h0, i_arst_n = 1'h0, i_req = 1'h0, i_we = 1'h0, i_sleep = 1'h0;
  logic [14:0] i_addr = 15'h0000, o_mem_addr, held_addr;
  logic [7:0] i_wdata = 8'h00, o_rdata, o_dq, mem_q, dq_wire, dq_last = 8'h00;
  logic o_ready, o_rvalid, o_chip_enable_n, o_store_gate_n, o_output_gate_n, o_dq_oe_n, mem_drive, was_wr;
  int err_count = 0;
  int n_checks = 0;
  always #4 i_clock = ~i_clock;
  // released lines flip each cycle so a stale value never reads back
  assign dq_wire = !o_dq_oe_n ? o_dq : mem_drive ? mem_q : ~dq_last;
  always @(posedge i_clock) dq_last <= dq_wire;
  asr_host uut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_req(i_req), .i_we(i_we), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_sleep(i_sleep), .o_ready(o_ready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_mem_addr(o_mem_addr), .o_chip_enable_n(o_chip_enable_n), .o_store_gate_n(o_store_gate_n),
    .o_output_gate_n(o_output_gate_n), .i_dq(dq_wire), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n));
  asr_mem_model mem (.i_addr(o_mem_addr), .i_chip_enable_n(o_chip_enable_n), .i_store_gate_n(o_store_gate_n),
    .i_output_gate_n(o_output_gate_n), .i_dq(dq_wire), .o_dq(mem_q), .o_drive(mem_drive));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait for ready (sel 0) or read valid (sel 1)
  task automatic wait_hi(input logic sel, output int n);
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
      if (n > 80) begin
        err_count++;
        end_of_test();
      end
    end while ((sel ? o_rvalid : o_ready) !== 1'h1);
  endtask
  task automatic op(input logic we, input logic [14:0] a, input logic [7:0] d, output int n);
    wait_hi(1'h0, n);
    @(posedge i_clock);
    i_req <= 1'h1;
    i_we <= we;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_req <= 1'h0;
    wait_hi(!we, n);
  endtask
  // ====================
  // pin discipline watched every cycle
  always @(posedge i_clock) begin
    if (i_arst_n) begin
      check({4'h0, mem_drive & !o_dq_oe_n, !o_store_gate_n & !o_output_gate_n, i_sleep & !o_chip_enable_n,
        was_wr & !o_store_gate_n & (o_mem_addr != held_addr)}, 8'h00);
    end
    was_wr <= !o_store_gate_n;
    held_addr <= o_mem_addr;
  end
  // ====================
  // scenarios
  task automatic t_table;
    logic [14:0] a [4] = '{15'h0000, 15'h7FFF, 15'h2AAA, 15'h5555};
    logic [7:0] d [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
    int n;
    for (int i = 0; i < 4; i++) begin
      op(1'h1, a[i], d[i], n);
    end
    op(1'h1, 15'h0000, 8'hFF, n);
    for (int i = 0; i < 4; i++) begin
      op(1'h0, a[i], 8'h00, n);
      check(o_rdata, i == 0 ? 8'hFF : d[i]);
      check(8'(n), 8'(asr_pkg::CYC_ACCESS));
    end
    $display("table test done");
  endtask
  task automatic t_sleep;
    int n;
    wait_hi(1'h0, n);
    @(posedge i_clock);
    i_sleep <= 1'h1;
    repeat (10) @(posedge i_clock);
    i_sleep <= 1'h0;
    wait_hi(1'h0, n);
    check(8'(n), 8'(asr_pkg::CYC_RECOVER + 2));
    op(1'h0, 15'h7FFF, 8'h00, n);
    check(o_rdata, 8'h5A);
    $display("sleep test done");
  endtask
  initial begin
    repeat (6) @(posedge i_clock);
    i_arst_n <= 1'h1;
    repeat (2) @(posedge i_clock);
    t_table();
    t_sleep();
    end_of_test();
  end
  // hang guard
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule
